// >>> verilog/dtc_pkg.sv
//
// constants for the dialer tone control register bank
// assumes a 200 MHz pclk and an apb master with 32-bit data
//
// Behaviour
// - handsfree bit drives speakerphone output; readable; reset clears it
// - 4-bit gap code selects inter-digit pause in steps of about 94 ms
// - gap inserted after each pulse digit; no effect in tone mode
// - reset loads gap code 1000 (750 ms)
// - low-group enable readable, writable, reset to one
// - high-group enable readable, writable, reset to one
// - enables low,high: 00 dc, 01 high, 10 low, 11 dual tone
// - dial code maps to one of four high-group single-tone frequencies
// - dial code maps to one of four low-group single-tone frequencies
// - tone length bit: 1 gives 47 ms, 0 gives 94 ms; reset clears
// - without the build option the tone length is fixed at 94 ms
// - dial code write starts pulses or tone; interrupt when finished
// - dial method bit: 1 pulse, 0 tone; reset clears to tone
package dtc_pkg;
  // ****************************************
  // register map (word index, byte = 4*index)
  // ****************************************
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_METHOD = 16'hff10;
  localparam logic [15:0] IDX_HFREE  = 16'hff14;
  localparam logic [15:0] IDX_GAP    = 16'hff15;
  localparam logic [15:0] IDX_TONE   = 16'hff16;
  localparam logic [15:0] IDX_CODE   = 16'hff17;
  localparam logic [15:0] IDX_STAT   = 16'hff1e;
  localparam logic [15:0] IDX_MASK   = 16'hff1f;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIT_METHOD = 3;
  localparam int BIT_HFREE  = 3;
  localparam int BIT_TLEN   = 2;
  localparam int BIT_LOW    = 1;
  localparam int BIT_HIGH   = 0;
  localparam int BIT_DONE   = 0;
  localparam logic [3:0] RST_GAP  = 4'h8;
  localparam logic [3:0] RST_CODE = 4'h0;
  // ****************************************
  // timing (ns and derived cycles)
  // ****************************************
  localparam int CLK_NS       = 5;
  localparam int GAP_STEP_NS  = 93_750_000;
  localparam int TONE_SH_NS   = 47_000_000;
  localparam int TONE_LG_NS   = 94_000_000;
  localparam int PULSE_NS     = 100_000_000;
  localparam int GAP_STEP_CYC = GAP_STEP_NS / CLK_NS;
  localparam int TONE_SH_CYC  = (TONE_SH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TONE_LG_CYC  = (TONE_LG_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TEN_PULSES = 4'ha;
  typedef enum logic [1:0] {
    DTC_IDLE, DTC_TONE, DTC_PULSE, DTC_GAP
  } dtc_state_t;
endpackage : dtc_pkg

// >>> verilog/dtc_top.sv
//
// dialer tone control: apb register bank plus dial sequencer
// assumes a synchronous apb master on pclk and line circuitry that
// turns the level outputs into pulses and tones
//
`timescale 1ns/1ps
module dtc_top #(
  parameter int unsigned GAP_STEP_CYC = dtc_pkg::GAP_STEP_CYC,
  parameter int unsigned TONE_SH_CYC  = dtc_pkg::TONE_SH_CYC,
  parameter int unsigned TONE_LG_CYC  = dtc_pkg::TONE_LG_CYC,
  parameter int unsigned PULSE_CYC    = dtc_pkg::PULSE_CYC,
  parameter bit          TONE_LEN_OPT = 1'b1
) (
  input  wire logic                       pclk,          // system clock
  input  wire logic                       presetn,       // async reset
  input  wire logic                       psel,          // apb select
  input  wire logic                       penable,       // apb enable
  input  wire logic                       pwrite,        // apb write
  input  wire logic [dtc_pkg::ADDR_W-1:0] paddr,         // byte address
  input  wire logic [31:0]                pwdata,        // write data
  output logic      [31:0]                prdata,        // read data
  output logic                            pready,        // apb ready
  output logic                            pslverr,       // unmapped
  output logic                            speakerphone_out, // handsfree
  output logic                            tone_low_en,   // low group
  output logic                            tone_high_en,  // high group
  output logic      [1:0]                 tone_row_sel,  // low freq
  output logic      [1:0]                 tone_col_sel,  // high freq
  output logic                            tone_on,       // tone phase
  output logic                            dial_pulse,    // make level
  output logic                            gap_active,    // digit gap
  output logic                            irq            // interrupt
);
  import dtc_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [1:0] col_of(input logic [3:0] c);
    unique case (c)
      4'h1, 4'h4, 4'h7, 4'hc: col_of = 2'h0;
      4'h2, 4'h5, 4'h8, 4'ha: col_of = 2'h1;
      4'h3, 4'h6, 4'h9, 4'hb: col_of = 2'h2;
      default:                col_of = 2'h3;
    endcase
  endfunction : col_of

  function automatic logic [1:0] row_of(input logic [3:0] c);
    unique case (c)
      4'h0, 4'h1, 4'h2, 4'h3: row_of = 2'h0;
      4'h4, 4'h5, 4'h6, 4'hd: row_of = 2'h1;
      4'h7, 4'h8, 4'h9, 4'hf: row_of = 2'h2;
      default:                row_of = 2'h3;
    endcase
  endfunction : row_of

  // ****************************************
  // registers and state
  // ****************************************
  logic        dial_method_select;
  logic        handsfree_ctrl;
  logic [3:0]  interdigit_gap;
  logic        tone_length_select;
  logic        low_group_enable;
  logic        high_group_enable;
  logic [3:0]  dial_code;
  logic [0:0]  int_stat;
  logic [0:0]  int_mask;
  dtc_state_t  state;
  dtc_state_t  next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [3:0]  left;
  logic [3:0]  next_left;
  logic        done;
  logic [0:0]  next_stat;

  // ****************************************
  // apb decode
  // ****************************************
  wire logic [15:0] idx      = paddr[17:2];
  wire logic        setup    = psel & ~penable;
  wire logic        wr_go    = psel & penable & pready & pwrite;
  wire logic        sel_meth = (idx == IDX_METHOD);
  wire logic        sel_hfr  = (idx == IDX_HFREE);
  wire logic        sel_gap  = (idx == IDX_GAP);
  wire logic        sel_tone = (idx == IDX_TONE);
  wire logic        sel_code = (idx == IDX_CODE);
  wire logic        sel_stat = (idx == IDX_STAT);
  wire logic        sel_mask = (idx == IDX_MASK);
  wire logic        hit      = sel_meth | sel_hfr | sel_gap | sel_tone
                             | sel_code | sel_stat | sel_mask;
  wire logic        start    = wr_go & sel_code;

  // read mux; unmapped words read as zero
  wire logic [3:0] rd_nib =
      sel_meth ? {dial_method_select, 3'h0} :
      sel_hfr  ? {handsfree_ctrl, 3'h0} :
      sel_gap  ? interdigit_gap :
      sel_tone ? {1'b0, tone_length_select, low_group_enable,
                  high_group_enable} :
      sel_code ? dial_code :
      sel_stat ? {3'h0, int_stat} :
      sel_mask ? {3'h0, int_mask} : 4'h0;

  // one wait-free access phase: ready and data follow the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? {28'h000_0000, rd_nib} : 32'h0000_0000;
    end
  end

  // ****************************************
  // control register writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dial_method_select <= 1'b0;
      handsfree_ctrl     <= 1'b0;
      interdigit_gap     <= RST_GAP;
    end else if (wr_go) begin
      if (sel_meth) dial_method_select <= pwdata[BIT_METHOD];
      if (sel_hfr)  handsfree_ctrl     <= pwdata[BIT_HFREE];
      if (sel_gap)  interdigit_gap     <= pwdata[3:0];
    end
  end

  // tone group enables, tone length and dial code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_group_enable   <= 1'b1;
      high_group_enable  <= 1'b1;
      tone_length_select <= 1'b0;
      dial_code          <= RST_CODE;
      int_mask           <= 1'b0;
    end else if (wr_go) begin
      if (sel_tone) begin
        low_group_enable   <= pwdata[BIT_LOW];
        high_group_enable  <= pwdata[BIT_HIGH];
        tone_length_select <= pwdata[BIT_TLEN];
      end
      if (sel_code) dial_code <= pwdata[3:0];
      if (sel_mask) int_mask  <= pwdata[BIT_DONE];
    end
  end

  // ****************************************
  // dial sequencer
  // ****************************************
  // without the build option the length bit is stored but ignored
  wire logic [31:0] tone_cyc = (TONE_LEN_OPT && tone_length_select)
                             ? TONE_SH_CYC : TONE_LG_CYC;
  wire logic [31:0] gap_cyc  = 32'(interdigit_gap) * GAP_STEP_CYC;
  wire logic [3:0]  pulses   = (pwdata[3:0] == 4'h0) ? TEN_PULSES
                                                     : pwdata[3:0];

  // a new code restarts the sequence even mid-digit, so software
  // must wait for the interrupt before writing the next digit
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_left  = left;
    done       = 1'b0;
    if (start) begin
      if (dial_method_select) begin
        next_state = DTC_PULSE;
        next_timer = PULSE_CYC - 1;
        next_left  = pulses;
      end else begin
        next_state = DTC_TONE;
        next_timer = tone_cyc - 1;
      end
    end else begin
      unique case (state)
        DTC_IDLE: ;
        DTC_TONE: begin
          if (timer == 32'h0000_0000) begin
            next_state = DTC_IDLE;
            done       = 1'b1;
          end else next_timer = timer - 1;
        end
        DTC_PULSE: begin
          if (timer != 32'h0000_0000) next_timer = timer - 1;
          else if (left == 4'h1) begin
            next_state = DTC_GAP;
            next_timer = gap_cyc - 1;
          end else begin
            next_left  = left - 4'h1;
            next_timer = PULSE_CYC - 1;
          end
        end
        DTC_GAP: begin
          if (timer == 32'h0000_0000) begin
            next_state = DTC_IDLE;
            done       = 1'b1;
          end else next_timer = timer - 1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DTC_IDLE;
      timer <= 32'h0000_0000;
      left  <= 4'h0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      left  <= next_left;
    end
  end

  // ****************************************
  // interrupt: sticky, write one to clear, set wins
  // ****************************************
  wire logic stat_clr = wr_go & sel_stat & pwdata[BIT_DONE];
  always_comb next_stat = (int_stat & ~stat_clr) | done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 1'b0;
      irq      <= 1'b0;
    end else begin
      int_stat <= next_stat;
      irq      <= |(int_stat & int_mask);
    end
  end

  // ****************************************
  // line and tone outputs
  // ****************************************
  // make half comes first in every pulse period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speakerphone_out <= 1'b0;
      tone_low_en      <= 1'b1;
      tone_high_en     <= 1'b1;
      tone_row_sel     <= 2'h0;
      tone_col_sel     <= 2'h3;
      tone_on          <= 1'b0;
      dial_pulse       <= 1'b0;
      gap_active       <= 1'b0;
    end else begin
      speakerphone_out <= handsfree_ctrl;
      tone_low_en      <= low_group_enable;
      tone_high_en     <= high_group_enable;
      tone_row_sel     <= row_of(dial_code);
      tone_col_sel     <= col_of(dial_code);
      tone_on          <= (next_state == DTC_TONE);
      dial_pulse       <= (next_state == DTC_PULSE)
                        && (next_timer >= PULSE_CYC / 2);
      gap_active       <= (next_state == DTC_GAP);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hfree_pin_a: assert property (
    wr_go && sel_hfr |=> ##1 speakerphone_out == $past(pwdata[BIT_HFREE], 2))
    else $error("speakerphone output does not follow handsfree write");
  gap_load_a: assert property (
    state == DTC_PULSE && timer == 0 && left == 4'h1 && !start
    |=> state == DTC_GAP && timer == $past(gap_cyc) - 1)
    else $error("inter-digit gap not loaded after last pulse");
  tone_nogap_a: assert property (
    start && !dial_method_select |=> state == DTC_TONE ##1 !gap_active)
    else $error("tone mode entered a gap");
  group_en_a: assert property (
    wr_go && sel_tone |=> ##1
    {tone_low_en, tone_high_en} == $past(pwdata[1:0], 2))
    else $error("tone group enables do not follow write");
  col_map_a: assert property (
    wr_go && sel_code && pwdata[3:0] == 4'hd |=> ##1 tone_col_sel == 2'h3)
    else $error("code d should select the fourth high tone");
  row_map_a: assert property (
    wr_go && sel_code && pwdata[3:0] == 4'hd |=> ##1 tone_row_sel == 2'h1)
    else $error("code d should select the second low tone");
  tone_long_a: assert property (
    start && !dial_method_select && !tone_length_select
    |=> timer == TONE_LG_CYC - 1)
    else $error("tone length bit zero must give long duration");
  tone_fixed_a: assert property (
    start && !dial_method_select && !TONE_LEN_OPT
    |=> timer == TONE_LG_CYC - 1)
    else $error("tone length bit must be ignored without the option");
  done_flag_a: assert property (
    state == DTC_GAP && timer == 0 && !start |=> int_stat[0])
    else $error("finished digit did not raise status");
  irq_level_a: assert property (
    int_stat[0] && int_mask[0] |=> irq)
    else $error("unmasked status did not raise interrupt");
  pulse_mode_a: assert property (
    start && dial_method_select |=> state == DTC_PULSE ##1 dial_pulse)
    else $error("pulse mode did not start pulses");
endmodule : dtc_top

// >>> verification/dtc_line_model.sv
// line-side model: tallies tone cycles, make pulses and digit gap cycles
// assumes the dialer level outputs are flops on pclk
`timescale 1ns/1ps
module dtc_line_model (
  input  wire logic pclk,       // system clock
  input  wire logic presetn,    // async reset
  input  wire logic clr,        // zero the tallies
  input  wire logic tone_on,    // tone phase
  input  wire logic dial_pulse, // make level
  input  wire logic gap_active, // digit gap
  output int        tone_len,   // cycles of tone
  output int        pulse_cnt,  // make pulses seen
  output int        gap_len     // cycles of gap
);
  logic pulse_q;
  // ****************************************
  // tallies
  // ****************************************
  // counted every cycle, so a one-cycle glitch still shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_len  <= 0;
      pulse_cnt <= 0;
      gap_len   <= 0;
      pulse_q   <= 1'b0;
    end else if (clr) begin
      tone_len  <= 0;
      pulse_cnt <= 0;
      gap_len   <= 0;
      pulse_q   <= dial_pulse;
    end else begin
      tone_len  <= tone_len + int'(tone_on);
      pulse_cnt <= pulse_cnt + int'(dial_pulse && !pulse_q);
      gap_len   <= gap_len + int'(gap_active);
      pulse_q   <= dial_pulse;
    end
  end
endmodule : dtc_line_model

// >>> verification/dialer_tone_control_tb_top.sv
// self-checking bench for the dialer tone control bank
// assumes dtc_top answers apb in one wait-free access cycle
`timescale 1ns/1ps
module dialer_tone_control_tb_top;
  import dtc_pkg::*;
  // ****************************************
  // signals and model state
  // ****************************************
  localparam int G = 4;
  localparam int P = 6;
  localparam logic [31:0] COL_MAP = 32'hfc99_2493;
  localparam logic [31:0] ROW_MAP = 32'hb7fa_9500;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic clr = 0, pready, pslverr, speakerphone_out, irq;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic tone_low_en, tone_high_en, tone_on, dial_pulse, gap_active, err;
  logic [1:0] tone_row_sel, tone_col_sel;
  int tone_len, pulse_cnt, gap_len, failures = 0, total_checks = 0;
  int c, g, fix_len;
  logic fix_tone_on, fix_pulse, fix_gap;
  always #2.5 pclk = ~pclk;
  dtc_top #(.GAP_STEP_CYC(G), .TONE_SH_CYC(5), .TONE_LG_CYC(10),
            .PULSE_CYC(P)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .speakerphone_out(speakerphone_out),
    .tone_low_en(tone_low_en), .tone_high_en(tone_high_en),
    .tone_row_sel(tone_row_sel), .tone_col_sel(tone_col_sel),
    .tone_on(tone_on), .dial_pulse(dial_pulse),
    .gap_active(gap_active), .irq(irq));
  dtc_line_model i_line (.pclk(pclk), .presetn(presetn), .clr(clr),
    .tone_on(tone_on), .dial_pulse(dial_pulse),
    .gap_active(gap_active), .tone_len(tone_len),
    .pulse_cnt(pulse_cnt), .gap_len(gap_len));
  // second copy built without the tone length option
  dtc_top #(.GAP_STEP_CYC(G), .TONE_SH_CYC(5), .TONE_LG_CYC(10),
            .PULSE_CYC(P), .TONE_LEN_OPT(1'b0)) i_dut_fix (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .speakerphone_out(), .tone_low_en(),
    .tone_high_en(), .tone_row_sel(), .tone_col_sel(),
    .tone_on(fix_tone_on), .dial_pulse(fix_pulse),
    .gap_active(fix_gap), .irq());
  dtc_line_model i_line_fix (.pclk(pclk), .presetn(presetn), .clr(clr),
    .tone_on(fix_tone_on), .dial_pulse(fix_pulse),
    .gap_active(fix_gap), .tone_len(fix_len), .pulse_cnt(),
    .gap_len());
  // ****************************************
  // tasks
  // ****************************************
  task automatic fail(input string m);
    failures++;
    $display("ERROR t=%0t %s", $time, m);
  endtask : fail
  task automatic chk_pin(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : chk_pin
  task automatic chk_rd(input logic [31:0] exp);
    total_checks++;
    if (rd !== exp) fail($sformatf("read got %h exp %h", rd, exp));
  endtask : chk_rd
  // holds the request until pready is seen; bounded so a hang fails
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20) fail("no pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    chk_rd(e);
  endtask : rdchk
  // writes a dial code, waits for the done interrupt, clears it
  task automatic dial(input logic [3:0] code);
    int k;
    k = 0;
    clr <= 1'b1;
    apb(1'b1, IDX_CODE, {28'h000_0000, code});
    clr <= 1'b0;
    while (irq !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) fail("no irq");
    apb(1'b1, IDX_STAT, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 0, "irq clear");
  endtask : dial
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge pclk);
    fail("watchdog");
    give_verdict();
  end
  initial begin
    void'($urandom(30320));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_HFREE, 32'h0000_0000);
    rdchk(IDX_GAP, 32'h0000_0008);
    rdchk(IDX_TONE, 32'h0000_0003);
    rdchk(IDX_METHOD, 32'h0000_0000);
    chk_pin({tone_low_en, tone_high_en}, 2'b11, "enables");
    $display("test reset done");
    for (int i = 1; i >= 0; i--) begin
      // speakerphone pin function is selected outside this bank
      apb(1'b1, IDX_HFREE, 32'(i) << 3);
      repeat (3) @(posedge pclk);
      chk_pin(speakerphone_out, 32'(i), "handsfree");
      rdchk(IDX_HFREE, 32'(i) << 3);
    end
    $display("test handsfree done");
    apb(1'b1, IDX_MASK, 32'h0000_0001);
    // every dial code once; tone bits cycle through all eight settings
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, IDX_TONE, 32'(i % 8));
      repeat (3) @(posedge pclk);
      chk_pin({tone_low_en, tone_high_en}, i % 4, "groups");
      rdchk(IDX_TONE, 32'(i % 8));
      dial(4'(i));
      chk_pin(tone_len, (i % 8 >= 4) ? 5 : 10, "tone len");
      chk_pin(fix_len, 10, "fixed len");
      chk_pin(tone_row_sel, ROW_MAP[2*i +: 2], "row");
      chk_pin(tone_col_sel, COL_MAP[2*i +: 2], "col");
      chk_pin(gap_len + pulse_cnt, 0, "tone gap");
    end
    $display("test tone done");
    apb(1'b1, IDX_METHOD, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      g = $urandom_range(3, 1);
      c = (i == 0) ? 0 : $urandom_range(9, 1);
      apb(1'b1, IDX_GAP, 32'(g));
      rdchk(IDX_GAP, 32'(g));
      dial(4'(c));
      chk_pin(pulse_cnt, (c == 0) ? 10 : c, "pulses");
      chk_pin(gap_len, g * G, "gap");
      chk_pin(tone_len, 0, "no tone");
    end
    $display("test pulse done");
    apb(1'b1, IDX_METHOD, 32'h0000_0000);
    apb(1'b1, IDX_MASK, 32'h0000_0000);
    apb(1'b1, IDX_CODE, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    chk_pin(irq, 0, "masked irq");
    rdchk(IDX_STAT, 32'h0000_0001);
    apb(1'b1, IDX_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 1, "unmasked irq");
    apb(1'b1, IDX_STAT, 32'h0000_0001);
    rdchk(IDX_STAT, 32'h0000_0000);
    apb(1'b1, 16'h0100, 32'h0000_000f);
    chk_pin(err, 1, "slverr wr");
    rdchk(16'h0100, 32'h0000_0000);
    chk_pin(err, 1, "slverr rd");
    $display("test irq and unmapped done");
    give_verdict();
  end
endmodule : dialer_tone_control_tb_top
